// ### logic/bias_enable_voltage_regs.sv
// Block enable and output voltage registers with backlight start control
`timescale 1ns/1ps
// Contract
// - Backlight runs only while enabled and bias soft-start is done.
// - Phase-shift bit 0 gives direct dimming, 1 gives staggered strings.
// - Phase-shift bit is sampled only when the backlight starts up.
// - Positive code resets 0x14; 5 V at 0xA, 0.1 V steps, 15 V at top.
// - Gate high code resets zero; 8 V plus 0.5 V per step to 26.5 V.
// - Gate low code resets zero; -6 V minus 0.5 V per step to -21.5 V.
// - Any source or gate output enable starts the shared source boost.
module bias_enable_voltage_regs
  import bias_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic bias_ss_done,
  output logic [7:0] rdata,
  output logic rd_valid,
  output logic backlight_on,
  output logic phase_shift_active,
  output logic source_boost_converter_en,
  output logic boost_en,
  output logic pos_out_en,
  output logic neg_out_en,
  output logic gate_high_en,
  output logic gate_low_en,
  output logic [15:0] pos_mv,
  output logic [15:0] gate_high_mv,
  output logic [15:0] gate_low_mag_mv
);
  // ==========================================================
  // Register file
  logic [ENABLES_W-1:0] enables;
  logic [POS_W-1:0] pos_code;
  logic [GATE_HIGH_W-1:0] gate_high_code;
  logic [GATE_LOW_W-1:0] gate_low_code;
  logic [ENABLES_W-1:0] next_enables;
  logic [POS_W-1:0] next_pos_code;
  logic [GATE_HIGH_W-1:0] next_gate_high_code;
  logic [GATE_LOW_W-1:0] next_gate_low_code;

  always_comb begin
    next_enables = enables;
    next_pos_code = pos_code;
    next_gate_high_code = gate_high_code;
    next_gate_low_code = gate_low_code;
    if (wr_en) begin
      case (addr)
        OFF_BLOCK_ENABLES: next_enables = wdata[ENABLES_W-1:0];
        OFF_POS_VOLTAGE: next_pos_code = wdata;
        OFF_GATE_HIGH: next_gate_high_code = wdata[GATE_HIGH_W-1:0];
        OFF_GATE_LOW: next_gate_low_code = wdata[GATE_LOW_W-1:0];
        default: next_enables = enables;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enables <= RST_BLOCK_ENABLES;
      pos_code <= RST_POS_VOLTAGE;
      gate_high_code <= RST_GATE_HIGH;
      gate_low_code <= RST_GATE_LOW;
    end else begin
      enables <= next_enables;
      pos_code <= next_pos_code;
      gate_high_code <= next_gate_high_code;
      gate_low_code <= next_gate_low_code;
    end
  end

  assign boost_en = enables[BIT_BOOST_EN];
  assign pos_out_en = enables[BIT_POS_EN];
  assign neg_out_en = enables[BIT_NEG_EN];
  assign gate_high_en = enables[BIT_GATE_HIGH_EN];
  assign gate_low_en = enables[BIT_GATE_LOW_EN];

  // ==========================================================
  // Read port
  logic [7:0] next_rdata;
  logic next_rd_valid;

  always_comb begin
    next_rdata = rdata;
    next_rd_valid = rd_en;
    if (rd_en) begin
      case (addr)
        OFF_BLOCK_ENABLES: next_rdata = {1'b0, enables};
        OFF_POS_VOLTAGE: next_rdata = pos_code;
        OFF_GATE_HIGH: next_rdata = {2'b00, gate_high_code};
        OFF_GATE_LOW: next_rdata = {3'b000, gate_low_code};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rd_valid <= next_rd_valid;
    end
  end

  // ==========================================================
  // Soft-start done synchroniser
  // Comes from the analog bias section, so it is asynchronous here
  logic ss_meta;
  logic ss_sync;

  always_ff @(posedge clk) begin
    if (rst) begin
      ss_meta <= 1'b0;
      ss_sync <= 1'b0;
    end else begin
      ss_meta <= bias_ss_done;
      ss_sync <= ss_meta;
    end
  end

  // ==========================================================
  // Backlight start and source boost control
  logic next_backlight_on;
  logic next_phase_shift_active;
  logic next_source_boost;

  always_comb begin
    next_backlight_on = enables[BIT_BACKLIGHT] & ss_sync;
    next_phase_shift_active = phase_shift_active;
    // Latched on the off-to-on edge only; later writes wait for a restart
    if (next_backlight_on && !backlight_on) begin
      next_phase_shift_active = enables[BIT_PHASE_SHIFT];
    end
    next_source_boost = enables[BIT_BOOST_EN] | enables[BIT_POS_EN]
      | enables[BIT_NEG_EN] | enables[BIT_GATE_HIGH_EN]
      | enables[BIT_GATE_LOW_EN];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      backlight_on <= 1'b0;
      phase_shift_active <= 1'b0;
      source_boost_converter_en <= 1'b0;
    end else begin
      backlight_on <= next_backlight_on;
      phase_shift_active <= next_phase_shift_active;
      source_boost_converter_en <= next_source_boost;
    end
  end

  // ==========================================================
  // Voltage decoders
  volt_decode #(.CODE_W(POS_W), .BASE_MV(POS_BASE_MV),
    .STEP_MV(POS_STEP_MV), .LO_CODE(POS_LO_CODE),
    .HI_CODE(POS_HI_CODE)) pos_dec (
    .clk(clk), .rst(rst), .code(pos_code), .mv(pos_mv));
  volt_decode #(.CODE_W(GATE_HIGH_W), .BASE_MV(GATE_HIGH_BASE_MV),
    .STEP_MV(GATE_HIGH_STEP_MV), .LO_CODE(0),
    .HI_CODE(GATE_HIGH_HI_CODE)) gate_high_dec (
    .clk(clk), .rst(rst), .code(gate_high_code), .mv(gate_high_mv));
  volt_decode #(.CODE_W(GATE_LOW_W), .BASE_MV(GATE_LOW_BASE_MV),
    .STEP_MV(GATE_LOW_STEP_MV), .LO_CODE(0),
    .HI_CODE(GATE_LOW_HI_CODE)) gate_low_dec (
    .clk(clk), .rst(rst), .code(gate_low_code), .mv(gate_low_mag_mv));

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_write_pos;
    wr_en && !rd_en && addr == OFF_POS_VOLTAGE;
  endsequence
  sequence s_read_pos;
    rd_en && !wr_en && addr == OFF_POS_VOLTAGE;
  endsequence
  // Both start conditions; soft-start is the synchronised copy
  sequence s_bl_ready;
    enables[BIT_BACKLIGHT] && ss_sync;
  endsequence

  a_readback_pos: assert property (
    s_write_pos ##1 s_read_pos |=> rd_valid && rdata == $past(wdata, 2))
    else $error("positive code readback mismatch");
  a_reserved_zero: assert property (
    rd_en && addr == OFF_GATE_LOW |=> rdata[7:5] == 3'b000)
    else $error("unused bits not zero");
  a_bl_needs_ss: assert property (
    $rose(backlight_on) |-> $past(ss_sync) && $past(enables[BIT_BACKLIGHT]))
    else $error("backlight started without soft-start done");
  a_bl_stays_off: assert property (
    !enables[BIT_BACKLIGHT] |=> !backlight_on)
    else $error("backlight on while disabled");
  a_phase_sample: assert property (
    $rose(backlight_on)
    |-> phase_shift_active == $past(enables[BIT_PHASE_SHIFT]))
    else $error("phase shift not taken at startup");
  a_phase_hold: assert property (
    backlight_on && $past(backlight_on) |-> $stable(phase_shift_active))
    else $error("phase shift changed while running");
  a_auto_boost: assert property (
    enables[BIT_POS_EN] || enables[BIT_NEG_EN] || enables[BIT_GATE_HIGH_EN]
    || enables[BIT_GATE_LOW_EN] |=> source_boost_converter_en)
    else $error("source boost not started");
  a_pos_reset: assert property (
    $past(rst) |-> pos_code == RST_POS_VOLTAGE ##1 pos_mv == 16'h1770)
    else $error("positive code reset value wrong");
  a_bl_starts: assert property (
    s_bl_ready |=> backlight_on)
    else $error("backlight not started when ready");
  a_rd_valid: assert property (
    rd_en |=> rd_valid)
    else $error("read answer missing");
  a_unmapped_zero: assert property (
    rd_en && addr > OFF_GATE_LOW |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_enables_reset: assert property (
    $past(rst) |-> enables == RST_BLOCK_ENABLES)
    else $error("enable register reset value wrong");
endmodule

// ### logic/volt_decode.sv
// Registered code to millivolt decoder with clamping at both ends
`timescale 1ns/1ps
module volt_decode #(
  parameter int CODE_W = 8,
  parameter int BASE_MV = 5000,
  parameter int STEP_MV = 100,
  parameter int LO_CODE = 0,
  parameter int HI_CODE = 255
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [CODE_W-1:0] code,
  output logic [15:0] mv
);
  // ==========================================================
  // Decode
  logic [15:0] next_mv;

  // Codes outside the documented span clamp to the nearest end
  function automatic logic [15:0] to_mv(input logic [CODE_W-1:0] c);
    int k;
    begin
      k = int'(c);
      if (k < LO_CODE) begin
        k = LO_CODE;
      end
      if (k > HI_CODE) begin
        k = HI_CODE;
      end
      to_mv = 16'(BASE_MV + (k - LO_CODE) * STEP_MV);
    end
  endfunction

  always_comb begin
    next_mv = to_mv(code);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mv <= 16'h0000;
    end else begin
      mv <= next_mv;
    end
  end

  // ==========================================================
  // Checks
  localparam logic [15:0] TOP_MV =
    16'(BASE_MV + (HI_CODE - LO_CODE) * STEP_MV);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_mv_clamp_top: assert property (
    !$past(rst) && int'(code) >= HI_CODE |=> mv == TOP_MV)
    else $error("decoded voltage not at top of span");
  a_mv_linear_step: assert property (
    !$past(rst) && int'(code) > LO_CODE && int'(code) <= HI_CODE
    && int'(code) == int'($past(code)) + 1
    |=> mv == 16'($past(mv) + 16'(STEP_MV)))
    else $error("decoded voltage step wrong");
  a_mv_base: assert property (
    int'(code) <= LO_CODE |=> mv == 16'(BASE_MV))
    else $error("decoded voltage base wrong");
endmodule

// ### pkg/bias_regs_pkg.sv
// Offsets, reset values, field positions and voltage scales of the bias regs
package bias_regs_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_BLOCK_ENABLES = 8'h02;
  localparam logic [7:0] OFF_POS_VOLTAGE = 8'h03;
  localparam logic [7:0] OFF_GATE_HIGH = 8'h04;
  localparam logic [7:0] OFF_GATE_LOW = 8'h05;
  // ==========================================================
  // Reset values
  localparam logic [6:0] RST_BLOCK_ENABLES = 7'h01;
  localparam logic [7:0] RST_POS_VOLTAGE = 8'h14;
  localparam logic [5:0] RST_GATE_HIGH = 6'h00;
  localparam logic [4:0] RST_GATE_LOW = 5'h00;
  // ==========================================================
  // Field positions and widths
  localparam int BIT_PHASE_SHIFT = 0;
  localparam int BIT_BACKLIGHT = 1;
  localparam int BIT_GATE_LOW_EN = 2;
  localparam int BIT_GATE_HIGH_EN = 3;
  localparam int BIT_NEG_EN = 4;
  localparam int BIT_POS_EN = 5;
  localparam int BIT_BOOST_EN = 6;
  localparam int ENABLES_W = 7;
  localparam int POS_W = 8;
  localparam int GATE_HIGH_W = 6;
  localparam int GATE_LOW_W = 5;
  // ==========================================================
  // Voltage scales in millivolts
  localparam int POS_BASE_MV = 5000;
  localparam int POS_STEP_MV = 100;
  localparam int POS_LO_CODE = 10;
  localparam int POS_HI_CODE = 110;
  localparam int GATE_HIGH_BASE_MV = 8000;
  localparam int GATE_HIGH_STEP_MV = 500;
  localparam int GATE_HIGH_HI_CODE = 37;
  localparam int GATE_LOW_BASE_MV = 6000;
  localparam int GATE_LOW_STEP_MV = 500;
  localparam int GATE_LOW_HI_CODE = 31;
endpackage

// ### tb/bias_enable_voltage_regs_tb_top.sv
// Self-checking bench for the enable and voltage registers
`timescale 1ns/1ps
module bias_enable_voltage_regs_tb_top;
  import bias_regs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bias_ss_done = 1'b0;
  logic wr_en, rd_en, rd_valid, backlight_on, phase_shift_active;
  logic source_boost_converter_en, boost_en, pos_out_en, neg_out_en;
  logic gate_high_en, gate_low_en;
  logic [7:0] addr, wdata, rdata;
  logic [15:0] pos_mv, gate_high_mv, gate_low_mag_mv;
  logic [4:0] en_bits;
  int fail_count = 0;
  int comparisons = 0;
  int b;
  logic [7:0] rd_q;
  logic rd_v;
  assign en_bits = {boost_en, pos_out_en, neg_out_en, gate_high_en,
                    gate_low_en};
  always #25 clk = ~clk;
  bias_host_model host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid));
  bias_enable_voltage_regs dut (.clk(clk), .rst(rst), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .bias_ss_done(bias_ss_done), .rdata(rdata), .rd_valid(rd_valid),
    .backlight_on(backlight_on), .phase_shift_active(phase_shift_active),
    .source_boost_converter_en(source_boost_converter_en),
    .boost_en(boost_en), .pos_out_en(pos_out_en), .neg_out_en(neg_out_en),
    .gate_high_en(gate_high_en), .gate_low_en(gate_low_en),
    .pos_mv(pos_mv), .gate_high_mv(gate_high_mv),
    .gate_low_mag_mv(gate_low_mag_mv));
  // ==========================================================
  // Compare tasks
  task automatic chk1(input string n, input logic e, input logic s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk16(input string n, input logic [15:0] e,
                       input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    chk1("rd_valid", 1'b1, v);
    chk8("rdata", e, d);
  endtask
  // Decoder lags the register by one edge, so look one cycle later
  task automatic vchk(input logic [7:0] a, input logic [7:0] c,
                      input logic [15:0] e);
    host.wr(a, c);
    @(negedge clk);
    if (a == OFF_POS_VOLTAGE) chk16("pos_mv", e, pos_mv);
    else if (a == OFF_GATE_HIGH) chk16("gate_high_mv", e, gate_high_mv);
    else chk16("gate_low_mag_mv", e, gate_low_mag_mv);
  endtask
  // Bounded wait, then the level must match
  task automatic wait_bl(input logic e);
    int i;
    for (i = 0; i < 8 && backlight_on !== e; i++) @(negedge clk);
    chk1("backlight_on", e, backlight_on);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Watchdog, far beyond the hundred-odd cycles the tests need
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk16("pos_mv", 16'h1770, pos_mv);
    chk16("gate_high_mv", 16'h1f40, gate_high_mv);
    chk16("gate_low_mag_mv", 16'h1770, gate_low_mag_mv);
    rchk(OFF_BLOCK_ENABLES, 8'h01);
    rchk(OFF_POS_VOLTAGE, 8'h14);
    rchk(OFF_GATE_HIGH, 8'h00);
    rchk(OFF_GATE_LOW, 8'h00);
    $display("test reset values done");
    host.wr(OFF_POS_VOLTAGE, 8'ha5);
    rchk(OFF_POS_VOLTAGE, 8'ha5);
    host.wr(OFF_GATE_HIGH, 8'hff);
    rchk(OFF_GATE_HIGH, 8'h3f);
    host.wr(OFF_GATE_LOW, 8'hff);
    rchk(OFF_GATE_LOW, 8'h1f);
    host.wr(OFF_BLOCK_ENABLES, 8'hff);
    rchk(OFF_BLOCK_ENABLES, 8'h7f);
    chk1("backlight_on", 1'b0, backlight_on);
    host.wr(8'h07, 8'h5a);
    rchk(8'h07, 8'h00);
    host.wr_rd(OFF_POS_VOLTAGE, 8'h3c, rd_q, rd_v);
    chk1("rd_valid", 1'b1, rd_v);
    chk8("rdata", 8'h3c, rd_q);
    $display("test readback done");
    // Positive ends, gate tops and first steps, clamps and one interior step
    vchk(OFF_POS_VOLTAGE, 8'h00, 16'h1388);
    vchk(OFF_POS_VOLTAGE, 8'h0a, 16'h1388);
    vchk(OFF_POS_VOLTAGE, 8'h6d, 16'h3a34);
    vchk(OFF_POS_VOLTAGE, 8'h6e, 16'h3a98);
    vchk(OFF_POS_VOLTAGE, 8'hff, 16'h3a98);
    vchk(OFF_GATE_HIGH, 8'h01, 16'h2134);
    vchk(OFF_GATE_HIGH, 8'h25, 16'h6784);
    vchk(OFF_GATE_HIGH, 8'h3f, 16'h6784);
    vchk(OFF_GATE_LOW, 8'h01, 16'h1964);
    vchk(OFF_GATE_LOW, 8'h1f, 16'h53fc);
    $display("test voltage decode done");
    for (b = 2; b < 7; b++) begin
      host.wr(OFF_BLOCK_ENABLES, 8'h01 << b);
      @(negedge clk);
      chk1("source boost", 1'b1, source_boost_converter_en);
      chk1("enable bit", 1'b1, en_bits[b-2]);
    end
    host.wr(OFF_BLOCK_ENABLES, 8'h00);
    @(negedge clk);
    chk1("source boost", 1'b0, source_boost_converter_en);
    $display("test source boost done");
    host.wr(OFF_BLOCK_ENABLES, 8'h03);
    repeat (6) @(negedge clk);
    chk1("backlight_on", 1'b0, backlight_on);
    bias_ss_done = 1'b1;
    wait_bl(1'b1);
    chk1("phase_shift_active", 1'b1, phase_shift_active);
    host.wr(OFF_BLOCK_ENABLES, 8'h02);
    repeat (3) @(negedge clk);
    chk1("phase_shift_active", 1'b1, phase_shift_active);
    host.wr(OFF_BLOCK_ENABLES, 8'h00);
    wait_bl(1'b0);
    host.wr(OFF_BLOCK_ENABLES, 8'h02);
    wait_bl(1'b1);
    chk1("phase_shift_active", 1'b0, phase_shift_active);
    bias_ss_done = 1'b0;
    wait_bl(1'b0);
    $display("test backlight start done");
    // Reset in mid-run with the backlight on and fields written
    bias_ss_done = 1'b1;
    wait_bl(1'b1);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk1("backlight_on", 1'b0, backlight_on);
    @(negedge clk);
    chk16("gate_high_mv", 16'h1f40, gate_high_mv);
    rchk(OFF_BLOCK_ENABLES, 8'h01);
    rchk(OFF_GATE_HIGH, 8'h00);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule

// ### tb/bias_host_model.sv
// Host side model issuing byte writes and reads on the register port
`timescale 1ns/1ps
module bias_host_model (
  input wire logic clk,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rd_valid
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // ==========================================================
  // Access tasks
  // Released lines show the inverse, so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(negedge clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk);
    v = rd_valid;
    d = rdata;
    rd_en = 1'b0;
    addr = ~a;
  endtask
  // Write then read in the very next cycle, no idle gap
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic v);
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = 1'b1;
    wdata = ~d;
    @(negedge clk);
    v = rd_valid;
    q = rdata;
    rd_en = 1'b0;
    addr = ~a;
  endtask
endmodule
